// ### slwc_defines.svh
// Register indices, field positions, reset values and timing counts of the
// segment LCD waveform control block. Assumes inclusion by bare name.
//
// Functional notes
// - Waveform base clock is reference clock divided by ratio from three-bit select.
// - Backplane and frontplane waveform generators both run from the base clock.
// - One frame lasts base clock period times backplane count of the duty.
// - Low current set, fast charge clear: high-resistance ladder selected all the time.
// - Fast charge: low-resistance ladder briefly at each switching edge, else high-resistance.
// - Fast charge pulse is base period divided by 32, 64 or 128.
// - Four-bit contrast code with sixteen settings goes to the bias generator.
// - Waveforms continue normally while the processor sits in wait mode.
// - Stop with oscillator-run-in-stop set keeps the display running.
// - Stop with oscillator-run-in-stop clear halts waveform generation.
// - Register contents survive entry into and exit from stop mode.
// - A display halted by stop resumes once an external interrupt wakes.
// - Thirty display pins: backplanes, frontplanes and one shared pin.
// - Eight frontplanes shared with port pins, two group bits pick display use.
// - Shared pin is fourth backplane at 1/4 duty, first frontplane otherwise.
// - Each frontplane waveform depends on duty and its stored segment bits.
// - Waveforms driven only while display enable is one; reset clears it.
// - Fast charge and low current bits are read/write and reset to zero.
// - Sixteen software registers: control, clock and fourteen segment data.
// - Ladder decode: low current clear default; low only high-resistance; both fast charge.
// - Width codes 00, 01, 10 give base/32, /64, /128 pulses; 11 unused.
// - Duty codes 00 static, 01 one third, 10 one quarter; reset clears.
// - Divider codes 000 to 110 give 128 to 65536; 111 reserved; reset clears.
`ifndef SLWC_DEFINES_SVH
`define SLWC_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define SLWC_IDX_CLOCK        8'h4f
`define SLWC_IDX_CONTROL      8'h51
`define SLWC_IDX_DATA_FIRST   8'h52
`define SLWC_IDX_DATA_LAST    8'h5f

// Control register fields.
`define SLWC_CTL_ENABLE       7
`define SLWC_CTL_FAST_CHARGE  5
`define SLWC_CTL_LOW_CURRENT  4
`define SLWC_CTL_CONTRAST_LSB 0

// Clock register fields.
`define SLWC_CLK_WIDTH_LSB    5
`define SLWC_CLK_DUTY_LSB     3
`define SLWC_CLK_DIV_LSB      0

// Reset values.
`define SLWC_CTL_RESET        8'h00
`define SLWC_CLK_RESET        7'h00
`define SLWC_DATA_RESET       8'h00

// Divider and pulse timing, as powers of two of reference clock edges.
`define SLWC_DIV_LOW_SHIFT    5'h07
`define SLWC_DIV_HIGH_SHIFT   5'h0e
`define SLWC_DIV_RESERVED     3'h7
`define SLWC_CHG_BASE_SHIFT   5'h05
`define SLWC_CHG_UNUSED       2'h3

`endif

// ### slwc_pkg.sv
// Types shared by the segment LCD waveform control block.
// Assumes slwc_defines.svh carries the numeric constants.
package slwc_pkg;

   // Duty code; the encoding follows the field order directly.
   typedef enum logic [1:0] {
      SLWC_DUTY_STATIC,
      SLWC_DUTY_THIRD,
      SLWC_DUTY_QUARTER,
      SLWC_DUTY_UNUSED
   } slwc_duty_type;

   // Drive level for one pin: 0 supply, 1 two thirds, 2 one third, 3 bias.
   typedef logic [1:0] slwc_level_type;

endpackage : slwc_pkg

// ### slwc_waveform_control.sv
// Control and timing logic of a multiplexed segment LCD driver with an
// Avalon-MM register slave. Assumes one 100 MHz clock, a synchronous
// reference clock input sampled on clk, and analog pin drivers that turn
// each two-bit level code into the matching ladder voltage.
`timescale 1ns/1ps
`include "slwc_defines.svh"

module slwc_waveform_control #(
   parameter int ADDR_W = 10
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [ADDR_W-1:0]     avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  oscillator_reference_clock,
   input  wire logic                  stop_mode,
   input  wire logic                  wait_mode,
   input  wire logic                  oscillator_run_in_stop,
   input  wire logic                  wake_interrupt,
   input  wire logic                  port_c_low_display_select,
   input  wire logic                  port_c_high_display_select,
   output logic      [5:0]            backplane_outputs,
   output logic      [1:0]            shared_frontplane_backplane_pin,
   output logic      [51:0]           frontplane_outputs,
   output logic      [7:0]            port_pin_display_use,
   output logic                       ladder_connect,
   output logic                       ladder_high_resistance,
   output logic      [3:0]            contrast_level
);

   // The index occupies address bits above the byte lane bits.
   if (ADDR_W < 10) begin : g_addr_check
      $error("slwc_waveform_control needs ADDR_W of at least 10");
   end

   // Whole block state; outputs are read straight from these flip-flops.
   typedef struct packed {
      logic                          waitrequest;
      logic [31:0]                   readdata;
      logic                          display_enable;
      logic                          fast_charge_select;
      logic                          low_current_select;
      logic [3:0]                    contrast;
      logic [1:0]                    fast_charge_width_select;
      slwc_pkg::slwc_duty_type       duty;
      logic [2:0]                    base_clock_divider_select;
      logic [13:0][7:0]              segment_data;
      logic                          ref_prev;
      logic                          halted;
      logic [15:0]                   div_count;
      logic                          phase;
      logic [1:0]                    slot;
      logic [11:0]                   charge_count;
      logic [3:0][1:0]               bp_level;
      logic [26:0][1:0]              fp_level;
      logic [7:0]                    pin_display;
      logic                          ladder_on;
      logic                          ladder_hr;
   } slwc_state_type;

   slwc_state_type state_reg;
   slwc_state_type state_next;

   // Backplane level: the selected plane, and every plane at static duty, swings supply/bias, the rest
   // alternate between the two middle taps so unselected segments see 1/3.
   function automatic slwc_pkg::slwc_level_type bp_wave(
      input logic sel,
      input logic ph,
      input logic is_static
   );
      if (sel || is_static) begin
         bp_wave = ph ? 2'h3 : 2'h0;
      end else begin
         bp_wave = ph ? 2'h1 : 2'h2;
      end
   endfunction : bp_wave

   // Frontplane level: an on segment runs opposite to the selected plane.
   function automatic slwc_pkg::slwc_level_type fp_wave(
      input logic on,
      input logic ph,
      input logic is_static
   );
      if (on) begin
         fp_wave = ph ? 2'h0 : 2'h3;
      end else if (is_static) begin
         fp_wave = ph ? 2'h3 : 2'h0;
      end else begin
         fp_wave = ph ? 2'h2 : 2'h1;
      end
   endfunction : fp_wave

   logic [7:0]  idx;
   logic [31:0] read_value;
   logic [4:0]  ratio_shift;
   logic [15:0] half_last;
   logic [11:0] charge_len;
   logic [1:0]  slot_last;
   logic        is_static;
   logic        ref_tick;
   logic        seg_bit;
   logic [3:0]  data_idx;

   // Register decode and read mux; unmapped or misaligned words read zero.
   always_comb begin
      idx        = avs_address[9:2];
      read_value = 32'h0000_0000;
      if (avs_address[1:0] == 2'h0 && (avs_address >> 10) == '0) begin
         if (idx == `SLWC_IDX_CONTROL) begin
            read_value[7:0] = {state_reg.display_enable, 1'b0,
                               state_reg.fast_charge_select,
                               state_reg.low_current_select, state_reg.contrast};
         end else if (idx == `SLWC_IDX_CLOCK) begin
            read_value[7:0] = {1'b0, state_reg.fast_charge_width_select,
                               state_reg.duty, state_reg.base_clock_divider_select};
         end else if (idx >= `SLWC_IDX_DATA_FIRST && idx <= `SLWC_IDX_DATA_LAST) begin
            read_value[7:0] = state_reg.segment_data[4'(idx - `SLWC_IDX_DATA_FIRST)];
         end
      end
   end

   // Divider ratio as a power of two; codes 4..6 jump to the high range.
   always_comb begin
      if (state_reg.base_clock_divider_select[2]) begin
         ratio_shift = `SLWC_DIV_HIGH_SHIFT + {3'h0, state_reg.base_clock_divider_select[1:0]};
      end else begin
         ratio_shift = `SLWC_DIV_LOW_SHIFT + {3'h0, state_reg.base_clock_divider_select[1:0]};
      end
      half_last = 16'((17'h00001 << (ratio_shift - 5'h01)) - 17'h00001);
      // Pulse of ratio/32, /64 or /128 reference edges; code 11 gives none.
      if (state_reg.fast_charge_width_select == `SLWC_CHG_UNUSED) begin
         charge_len = 12'h000;
      end else begin
         charge_len = 12'h001 << (ratio_shift - `SLWC_CHG_BASE_SHIFT
                                  - {3'h0, state_reg.fast_charge_width_select});
      end
      unique case (state_reg.duty)
         slwc_pkg::SLWC_DUTY_THIRD:   slot_last = 2'h2;
         slwc_pkg::SLWC_DUTY_QUARTER: slot_last = 2'h3;
         default:                     slot_last = 2'h0;
      endcase
      is_static = (slot_last == 2'h0);
   end

   // Next state: bus access, stop handling, base clock, waveforms, ladder.
   always_comb begin
      state_next = state_reg;
      seg_bit    = 1'b0;
      data_idx   = 4'h0;

      // One wait cycle per request; the access itself lands at the edge
      // where waitrequest is seen low, so read data stand at that edge.
      state_next.waitrequest = 1'b1;
      if ((avs_read || avs_write) && state_reg.waitrequest) begin
         state_next.waitrequest = 1'b0;
         state_next.readdata    = read_value;
      end
      if (avs_write && !state_reg.waitrequest && avs_byteenable[0]
          && avs_address[1:0] == 2'h0 && (avs_address >> 10) == '0) begin
         if (idx == `SLWC_IDX_CONTROL) begin
            state_next.display_enable     = avs_writedata[`SLWC_CTL_ENABLE];
            state_next.fast_charge_select = avs_writedata[`SLWC_CTL_FAST_CHARGE];
            state_next.low_current_select = avs_writedata[`SLWC_CTL_LOW_CURRENT];
            state_next.contrast = avs_writedata[`SLWC_CTL_CONTRAST_LSB +: 4];
         end else if (idx == `SLWC_IDX_CLOCK) begin
            state_next.fast_charge_width_select = avs_writedata[`SLWC_CLK_WIDTH_LSB +: 2];
            state_next.duty = slwc_pkg::slwc_duty_type'(avs_writedata[`SLWC_CLK_DUTY_LSB +: 2]);
            state_next.base_clock_divider_select = avs_writedata[`SLWC_CLK_DIV_LSB +: 3];
         end else if (idx >= `SLWC_IDX_DATA_FIRST && idx <= `SLWC_IDX_DATA_LAST) begin
            state_next.segment_data[4'(idx - `SLWC_IDX_DATA_FIRST)] = avs_writedata[7:0];
         end
      end

      // Stop without a running oscillator freezes the counters but leaves
      // every register as it was; wait mode is deliberately ignored.
      if (wake_interrupt) begin
         state_next.halted = 1'b0;
      end else if (stop_mode && !oscillator_run_in_stop) begin
         state_next.halted = 1'b1;
      end
      state_next.ref_prev = oscillator_reference_clock;
      ref_tick = oscillator_reference_clock && !state_reg.ref_prev
                 && !state_reg.halted
                 && state_reg.base_clock_divider_select != `SLWC_DIV_RESERVED;

      // Base clock: phase flips every half ratio; a full period is one slot.
      if (!state_reg.display_enable) begin
         state_next.div_count = 16'h0000;
         state_next.phase     = 1'b0;
         state_next.slot      = 2'h0;
         state_next.charge_count = 12'h000;
      end else if (ref_tick) begin
         if (state_reg.charge_count != 12'h000) begin
            state_next.charge_count = state_reg.charge_count - 12'h001;
         end
         // The >= keeps the count sane when software shrinks the ratio.
         if (state_reg.div_count >= half_last) begin
            state_next.div_count = 16'h0000;
            state_next.phase     = !state_reg.phase;
            state_next.charge_count = charge_len;
            if (state_reg.phase) begin
               if (state_reg.slot >= slot_last) begin
                  state_next.slot = 2'h0;
               end else begin
                  state_next.slot = state_reg.slot + 2'h1;
               end
            end
         end else begin
            state_next.div_count = state_reg.div_count + 16'h0001;
         end
      end

      // Pin levels from slot and phase of the base clock.
      for (int b = 0; b < 4; b++) begin
         state_next.bp_level[b] = bp_wave(state_reg.slot == 2'(b), state_reg.phase, is_static);
      end
      for (int k = 0; k < 27; k++) begin
         data_idx = 4'(k / 2);
         seg_bit  = state_reg.segment_data[data_idx][3'(((k % 2) * 4)) + {1'b0, state_reg.slot}];
         state_next.fp_level[k] = fp_wave(seg_bit, state_reg.phase, is_static);
      end
      // Shared pin follows the fourth backplane only at quarter duty.
      if (state_reg.duty == slwc_pkg::SLWC_DUTY_QUARTER) begin
         state_next.fp_level[0] = state_next.bp_level[3];
      end
      // Port pins given to general use carry no display drive.
      state_next.pin_display = {{4{port_c_high_display_select}},
                                {4{port_c_low_display_select}}};
      for (int k = 19; k < 27; k++) begin
         if (!state_next.pin_display[k-19]) begin
            state_next.fp_level[k] = 2'h0;
         end
      end

      // Disabled display sits at supply level with the ladder cut off.
      state_next.ladder_on = state_reg.display_enable;
      if (!state_reg.display_enable) begin
         state_next.bp_level = '0;
         state_next.fp_level = '0;
      end

      // Ladder choice; the fast charge pulse is the nonzero pulse count.
      state_next.ladder_hr = state_reg.display_enable && state_reg.low_current_select
                             && (!state_reg.fast_charge_select
                                 || state_next.charge_count == 12'h000);
   end

   // All state registers together; segment data get a defined value too.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg                          <= '0;
         state_reg.waitrequest              <= 1'b1;
         state_reg.display_enable           <= 1'(`SLWC_CTL_RESET >> `SLWC_CTL_ENABLE);
         state_reg.fast_charge_width_select <= 2'h0;
         state_reg.duty                     <= slwc_pkg::SLWC_DUTY_STATIC;
         state_reg.segment_data             <= {14{`SLWC_DATA_RESET}};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flip-flops.
   assign avs_readdata                    = state_reg.readdata;
   assign avs_waitrequest                 = state_reg.waitrequest;
   assign backplane_outputs               = {state_reg.bp_level[2], state_reg.bp_level[1],
                                             state_reg.bp_level[0]};
   assign shared_frontplane_backplane_pin = state_reg.fp_level[0];
   assign frontplane_outputs              = state_reg.fp_level[26:1];
   assign port_pin_display_use            = state_reg.pin_display;
   assign ladder_connect                  = state_reg.ladder_on;
   assign ladder_high_resistance          = state_reg.ladder_hr;
   assign contrast_level                  = state_reg.contrast;

endmodule : slwc_waveform_control

// ### slwc_properties.sv
// Port checker for the segment LCD waveform control block.
// Assumes it is bound to slwc_waveform_control and sees only its ports.
`timescale 1ns/1ps
module slwc_checker #(
   parameter int ADDR_W = 10
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              stop_mode,
   input wire logic              oscillator_run_in_stop,
   input wire logic              wake_interrupt,
   input wire logic              port_c_low_display_select,
   input wire logic              port_c_high_display_select,
   input wire logic [5:0]        backplane_outputs,
   input wire logic [1:0]        shared_frontplane_backplane_pin,
   input wire logic [51:0]       frontplane_outputs,
   input wire logic [7:0]        port_pin_display_use,
   input wire logic              ladder_connect,
   input wire logic [3:0]        contrast_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // A request taken while the slave is idle, and a control write as it lands.
   sequence bus_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence ctl_write;
      !avs_waitrequest && avs_write && avs_byteenable[0] && avs_address[9:2] == 8'h51;
   endsequence

   answer_one_cycle_a: assert property (bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer is not a single cycle");
   answer_needs_request_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without a request");
   read_upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   contrast_follow_a: assert property (ctl_write |-> ##2 contrast_level == $past(avs_writedata[3:0], 2))
      else $error("contrast output does not follow the control write");
   enable_follow_a: assert property (ctl_write |-> ##2 ladder_connect == $past(avs_writedata[7], 2))
      else $error("ladder connect does not follow enable");
   disabled_supply_a: assert property ((!ladder_connect) [*3] |-> backplane_outputs == 6'h00
      && frontplane_outputs == 52'h0 && shared_frontplane_backplane_pin == 2'h0)
      else $error("pins not at supply while disabled");
   port_use_copy_a: assert property ($past(rst_n) |-> port_pin_display_use == {{4{$past(
      port_c_high_display_select)}}, {4{$past(port_c_low_display_select)}}})
      else $error("port display use does not follow the selects");
   stop_freeze_a: assert property ((stop_mode && !oscillator_run_in_stop && !wake_interrupt) [*6]
      |-> $stable(backplane_outputs))
      else $error("backplanes move while halted in stop");
endmodule : slwc_checker

bind slwc_waveform_control slwc_checker #(.ADDR_W(ADDR_W)) i_slwc_checker (
   .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .stop_mode, .oscillator_run_in_stop, .wake_interrupt,
   .port_c_low_display_select, .port_c_high_display_select, .backplane_outputs,
   .shared_frontplane_backplane_pin, .frontplane_outputs, .port_pin_display_use,
   .ladder_connect, .contrast_level);

// ### slwc_glass_panel.sv
// Behavioural model of a passive segment glass on the display pins.
// Assumes level codes 0 supply, 1 two thirds, 2 one third, 3 bias.
`timescale 1ns/1ps
module slwc_glass_panel (
   input  wire logic        clk,
   input  wire logic [5:0]  backplane_outputs,
   input  wire logic [51:0] frontplane_outputs,
   output logic      [15:0] bp_edges,
   output logic      [15:0] half_cycles,
   output logic      [15:0] frame_cycles,
   output logic             seg_on
);
   logic [1:0]  last_bp = 2'h0;
   logic [15:0] run_cnt = 16'h0;
   logic [15:0] frame_cnt = 16'h0;
   logic        peak = 1'b0;

   initial {bp_edges, half_cycles, frame_cycles, seg_on} = '0;

   // A cell darkens only on full supply swing, so its peak is latched once per frame.
   always @(posedge clk) begin
      last_bp <= backplane_outputs[1:0];
      run_cnt <= run_cnt + 16'h1;
      frame_cnt <= frame_cnt + 16'h1;
      if ((frontplane_outputs[1:0] ^ backplane_outputs[1:0]) == 2'h3
          && backplane_outputs[1] == backplane_outputs[0]) peak <= 1'b1;
      if (backplane_outputs[1:0] != last_bp) begin
         bp_edges <= bp_edges + 16'h1;
         half_cycles <= run_cnt + 16'h1;
         run_cnt <= 16'h0;
         if (backplane_outputs[1:0] == 2'h0) begin
            frame_cycles <= frame_cnt + 16'h1;
            frame_cnt <= 16'h0;
            seg_on <= peak;
            peak <= 1'b0;
         end
      end
   end
endmodule : slwc_glass_panel

// ### slwc_waveform_control_test.sv
// Self-checking bench for the segment LCD waveform control block.
// Assumes the glass model on the pins and the bound port checker.
`timescale 1ns/1ps
module slwc_waveform_control_test;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, stop_mode, wait_mode;
   logic        oscillator_reference_clock, oscillator_run_in_stop, wake_interrupt;
   logic        port_c_low_display_select, port_c_high_display_select, seg_on;
   logic        ladder_connect, ladder_high_resistance;
   logic [9:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, contrast_level;
   logic [5:0]  backplane_outputs;
   logic [1:0]  shared_frontplane_backplane_pin;
   logic [51:0] frontplane_outputs;
   logic [7:0]  port_pin_display_use, rdat;
   logic [15:0] bp_edges, half_cycles, frame_cycles, e0;
   int          miscompares = 0, samples_checked = 0, cycles = 0, n;

   slwc_waveform_control i_slwc_waveform_control (.clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .oscillator_reference_clock, .stop_mode, .wait_mode, .oscillator_run_in_stop,
      .wake_interrupt, .port_c_low_display_select, .port_c_high_display_select,
      .backplane_outputs, .shared_frontplane_backplane_pin, .frontplane_outputs,
      .port_pin_display_use, .ladder_connect, .ladder_high_resistance, .contrast_level);
   slwc_glass_panel i_slwc_glass_panel (.clk, .backplane_outputs, .frontplane_outputs,
      .bp_edges, .half_cycles, .frame_cycles, .seg_on);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // One reference edge every two clocks keeps the divided periods short and exact.
   always @(posedge clk) oscillator_reference_clock <= ~oscillator_reference_clock;

   // A hang is cut short well after the roughly 50000 cycles the tests need.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // Holds the request until waitrequest is seen low, then takes the data and releases.
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, d};
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic check_registers;
      bus(1'b0, 8'h51, 8'h00, rdat);
      cmp("control reset", 16'h00, rdat);
      bus(1'b0, 8'h4f, 8'h00, rdat);
      cmp("clock reset", 16'h00, rdat);
      bus(1'b1, 8'h51, 8'hff, rdat);
      bus(1'b0, 8'h51, 8'h00, rdat);
      cmp("control rw", 16'hbf, rdat);
      cmp("contrast", 16'h0f, contrast_level);
      avs_byteenable <= 4'he;
      bus(1'b1, 8'h51, 8'h00, rdat);
      avs_byteenable <= 4'hf;
      bus(1'b1, 8'h40, 8'h55, rdat);
      bus(1'b0, 8'h51, 8'h00, rdat);
      cmp("masked write", 16'hbf, rdat);
      bus(1'b0, 8'h40, 8'h00, rdat);
      cmp("unmapped read", 16'h00, rdat);
      bus(1'b1, 8'h5f, 8'h0f, rdat);
      port_c_low_display_select <= 1'b1;
      bus(1'b0, 8'h5f, 8'h00, rdat);
      cmp("segment data", 16'h0f, rdat);
      cmp("port use", 16'h0f, port_pin_display_use);
   endtask : check_registers

   // Default, high-resistance and fast-charge-only ladder selections, low current clear in the last.
   task automatic check_ladder;
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 8'h51, {2'h2, i[1:0], 4'h0}, rdat);
         repeat (3) @(posedge clk);
         cmp("high resistance", 16'(i == 1), 16'(ladder_high_resistance));
      end
   endtask : check_ladder

   task automatic wait_ladder(input logic v);
      n = 0;
      while (ladder_high_resistance === v && n < 400) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_ladder

   // The pulse is ratio 128 shifted down by five plus width, in reference edges.
   task automatic check_pulse(input logic [1:0] w);
      bus(1'b1, 8'h4f, {1'b0, w, 5'h00}, rdat);
      bus(1'b1, 8'h51, 8'hb0, rdat);
      wait_ladder(1'b0);
      wait_ladder(1'b1);
      wait_ladder(1'b0);
      cmp("charge pulse", (w == 2'h3) ? 16'h0 : 16'h8 >> w, n[15:0]);
   endtask : check_pulse

   task automatic check_divider(input logic [2:0] c);
      e0 = c[2] ? 16'h4000 : 16'h0080 << c;
      bus(1'b1, 8'h4f, {5'h00, c}, rdat);
      repeat (2 * e0 + 8) @(posedge clk);
      cmp("half period", e0, half_cycles);
   endtask : check_divider

   task automatic check_frame(input logic [1:0] d, input logic [15:0] f, input logic [15:0] s);
      bus(1'b1, 8'h4f, {3'h0, d, 3'h0}, rdat);
      repeat (3 * f) @(posedge clk);
      cmp("frame length", f, frame_cycles);
      n = 0;
      repeat (f) begin
         @(posedge clk);
         n += int'(shared_frontplane_backplane_pin === 2'h0);
      end
      cmp("shared pin use", s, n[15:0]);
   endtask : check_frame

   task automatic check_segment;
      bus(1'b1, 8'h4f, 8'h00, rdat);
      for (int i = 1; i >= 0; i--) begin
         bus(1'b1, 8'h52, {3'h0, i[0], 4'h0}, rdat);
         repeat (600) @(posedge clk);
         cmp("segment state", 16'(i), 16'(seg_on));
      end
   endtask : check_segment

   task automatic snap_edges(input logic moving);
      repeat (10) @(posedge clk);
      e0 = bp_edges;
      repeat (600) @(posedge clk);
      cmp("waveform running", 16'(moving), 16'(bp_edges != e0));
   endtask : snap_edges

   task automatic check_stop;
      wait_mode <= 1'b1;
      bus(1'b1, 8'h51, 8'h85, rdat);
      snap_edges(1'b1);
      stop_mode <= 1'b1;
      snap_edges(1'b0);
      bus(1'b0, 8'h51, 8'h00, rdat);
      cmp("control in stop", 16'h85, rdat);
      wake_interrupt <= 1'b1;
      stop_mode <= 1'b0;
      @(posedge clk);
      wake_interrupt <= 1'b0;
      snap_edges(1'b1);
      oscillator_run_in_stop <= 1'b1;
      stop_mode <= 1'b1;
      snap_edges(1'b1);
      stop_mode <= 1'b0;
      bus(1'b1, 8'h51, 8'h00, rdat);
      repeat (4) @(posedge clk);
      cmp("disabled pins", 16'h0, {8'h00, backplane_outputs, shared_frontplane_backplane_pin});
      wait_mode <= 1'b0;
   endtask : check_stop

   initial begin
      {rst_n, avs_read, avs_write, oscillator_reference_clock, stop_mode, wait_mode} = '0;
      {oscillator_run_in_stop, wake_interrupt, port_c_low_display_select} = '0;
      {port_c_high_display_select, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      check_registers();
      check_ladder();
      for (int w = 0; w < 4; w++) check_pulse(w[1:0]);
      for (int c = 0; c < 5; c++) check_divider(c[2:0]);
      check_frame(2'h1, 16'd768, 16'd0);
      check_frame(2'h2, 16'd1024, 16'd128);
      check_segment();
      check_stop();
      test_done();
   end
endmodule : slwc_waveform_control_test
